/* File: dfal_regs.svh */
`ifndef DFAL_REGS_SVH
`define DFAL_REGS_SVH

// Register byte offsets, one aligned 32-bit word each
`define DFAL_TX_HEAD_OFS 8'h00
`define DFAL_TX_TAIL_OFS 8'h04
`define DFAL_RX_HEAD_OFS 8'h08
`define DFAL_RX_TAIL_OFS 8'h0C
`define DFAL_TX_WIN_OFS 8'h10
`define DFAL_RX_WIN_OFS 8'h14
`define DFAL_CTRL_OFS 8'h18
`define DFAL_STATUS_OFS 8'h1C

// Control register fields
`define DFAL_CTRL_LB_EN_BIT 0
`define DFAL_CTRL_FDX_BIT 1
`define DFAL_CTRL_SPEED_LSB 2
`define DFAL_CTRL_LBSEL_LSB 4
`define DFAL_CTRL_RESET 6'h00

// Status register fields
`define DFAL_STAT_LB_ACT_BIT 0
`define DFAL_STAT_TX_EMPTY_BIT 1
`define DFAL_STAT_TX_FULL_BIT 2
`define DFAL_STAT_RX_EMPTY_BIT 3
`define DFAL_STAT_RX_FULL_BIT 4

// AHB encodings
`define DFAL_HTRANS_NONSEQ 2'h2
`define DFAL_HTRANS_SEQ 2'h3

`endif

/* File: dfal_pkg.sv */
package dfal_pkg;

   // Bus slave phase
   typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_RD_WAIT, PH_RD_DONE} dfal_phase_type;

   // MAC speed selection
   typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000, SPEED_RSVD} dfal_speed_type;

endpackage : dfal_pkg

/* File: dfal_fifo_mem.sv */
`timescale 1ns/1ns
`default_nettype none

module dfal_fifo_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];

   // One entry is replaced per write
   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         mem_d[i] = mem_q[i];
      end
      if (wr_en)
      begin
         mem_d[wr_idx] = wr_data;
      end
   end

   // Cleared at reset so diagnostic reads never return unknowns
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         if (!reset_n)
         begin
            mem_q[i] <= '0;
         end
         else
         begin
            mem_q[i] <= mem_d[i];
         end
      end
   end

   assign rd_data = mem_q[rd_idx];

endmodule : dfal_fifo_mem

`default_nettype wire

/* File: dfal_top.sv */
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`include "dfal_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module dfal_top #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   input wire logic TX_IN_VALID,
   input wire logic [31:0] TX_IN_DATA,
   output logic TX_IN_READY,
   output logic LINE_TX_VALID,
   output logic [31:0] LINE_TX_DATA,
   input wire logic LINE_TX_READY,
   input wire logic LINE_RX_VALID,
   input wire logic [31:0] LINE_RX_DATA,
   output logic RX_OUT_VALID,
   output logic [31:0] RX_OUT_DATA,
   input wire logic RX_OUT_READY,
   output logic LOOPBACK_ACTIVE
);

   // One wrap bit tells full from empty without a separate fill counter
   localparam int PW = AW + 1;

   // Pointers carry one wrap bit above the index
   logic [PW-1:0] tx_head_q, tx_head_d, tx_tail_q, tx_tail_d;
   logic [PW-1:0] rx_head_q, rx_head_d, rx_tail_q, rx_tail_d;
   logic [5:0] ctrl_q, ctrl_d;
   dfal_pkg::dfal_phase_type phase_q, phase_d;
   logic [7:0] addr_q, addr_d;
   logic [31:0] rdata_q, rdata_d;

   // Occupancy flags, memory ports and bus strobes
   logic tx_empty, tx_full, rx_empty, rx_full;
   logic lb_act;
   logic [31:0] tx_rd_data, rx_rd_data;
   logic tx_wr_en, rx_wr_en;
   logic [AW-1:0] tx_wr_idx, rx_wr_idx;
   logic [31:0] tx_wr_data, rx_wr_data;
   logic tx_push, tx_pop, rx_push, rx_pop, lb_move;
   logic addr_take, wr_cyc, rd_cyc;
   logic sw_tx_win_wr, sw_rx_win_wr, sw_tx_win_rd, sw_rx_win_rd;
   dfal_pkg::dfal_speed_type speed;
   logic [1:0] rx_ctrl_loopback_sel;

   // Occupancy flags from the wrap bit
   assign tx_empty = (tx_head_q == tx_tail_q);
   assign rx_empty = (rx_head_q == rx_tail_q);
   assign tx_full = (tx_head_q[AW-1:0] == tx_tail_q[AW-1:0]) && (tx_head_q[AW] != tx_tail_q[AW]);
   assign rx_full = (rx_head_q[AW-1:0] == rx_tail_q[AW-1:0]) && (rx_head_q[AW] != rx_tail_q[AW]);

   // Loop only closes under full duplex, at any speed setting but 10 Mb/s, with normal select
   assign speed = dfal_pkg::dfal_speed_type'(ctrl_q[`DFAL_CTRL_SPEED_LSB +: 2]);
   assign rx_ctrl_loopback_sel = ctrl_q[`DFAL_CTRL_LBSEL_LSB +: 2];
   assign lb_act = ctrl_q[`DFAL_CTRL_LB_EN_BIT]
      && ctrl_q[`DFAL_CTRL_FDX_BIT]
      && (speed != dfal_pkg::SPEED_10)
      && (rx_ctrl_loopback_sel == 2'h0);
   assign LOOPBACK_ACTIVE = lb_act;

   // Bus decode; address phase taken only when the bus is ready
   assign addr_take = HSEL && HREADY
      && ((HTRANS == `DFAL_HTRANS_NONSEQ) || (HTRANS == `DFAL_HTRANS_SEQ));
   assign wr_cyc = (phase_q == dfal_pkg::PH_WRITE);
   assign rd_cyc = (phase_q == dfal_pkg::PH_RD_WAIT);
   assign sw_tx_win_wr = wr_cyc && (addr_q == `DFAL_TX_WIN_OFS);
   assign sw_rx_win_wr = wr_cyc && (addr_q == `DFAL_RX_WIN_OFS);
   assign sw_tx_win_rd = rd_cyc && (addr_q == `DFAL_TX_WIN_OFS);
   assign sw_rx_win_rd = rd_cyc && (addr_q == `DFAL_RX_WIN_OFS);

   // Reads stall one cycle so a just-written pointer is already in place
   assign HREADYOUT = (phase_q != dfal_pkg::PH_RD_WAIT);
   assign HRESP = 1'b0;
   assign HRDATA = rdata_q;

   // Traffic handshakes; a software window access holds off traffic on that port, so software wins
   assign TX_IN_READY = !tx_full && !sw_tx_win_wr;
   assign tx_push = TX_IN_VALID && TX_IN_READY;
   assign LINE_TX_VALID = !tx_empty && !lb_act;
   assign LINE_TX_DATA = tx_rd_data;
   assign lb_move = lb_act && !tx_empty && !rx_full && !sw_rx_win_wr
      && !sw_tx_win_rd;
   assign tx_pop = (LINE_TX_VALID && LINE_TX_READY && !sw_tx_win_rd) || lb_move;
   assign rx_push = lb_act ? lb_move
      : (LINE_RX_VALID && !rx_full && !sw_rx_win_wr);
   assign RX_OUT_VALID = !rx_empty;
   assign RX_OUT_DATA = rx_rd_data;
   assign rx_pop = RX_OUT_VALID && RX_OUT_READY && !sw_rx_win_rd;

   // Memory write ports: the window writes at the tail pointer
   always_comb
   begin
      tx_wr_en = sw_tx_win_wr || tx_push;
      tx_wr_idx = tx_tail_q[AW-1:0];
      tx_wr_data = sw_tx_win_wr ? HWDATA : TX_IN_DATA;
      rx_wr_en = sw_rx_win_wr || rx_push;
      rx_wr_idx = rx_tail_q[AW-1:0];
      if (sw_rx_win_wr)
      begin
         rx_wr_data = HWDATA;
      end
      else if (lb_act)
      begin
         rx_wr_data = tx_rd_data;
      end
      else
      begin
         rx_wr_data = LINE_RX_DATA;
      end
   end

   // Read ports follow the heads, so window reads and line data share one mux
   dfal_fifo_mem #(
      .WIDTH(32),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_tx_mem (
      .clk(CLK),
      .reset_n(RESET_N),
      .wr_en(tx_wr_en),
      .wr_idx(tx_wr_idx),
      .wr_data(tx_wr_data),
      .rd_idx(tx_head_q[AW-1:0]),
      .rd_data(tx_rd_data)
   );

   dfal_fifo_mem #(
      .WIDTH(32),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_rx_mem (
      .clk(CLK),
      .reset_n(RESET_N),
      .wr_en(rx_wr_en),
      .wr_idx(rx_wr_idx),
      .wr_data(rx_wr_data),
      .rd_idx(rx_head_q[AW-1:0]),
      .rd_data(rx_rd_data)
   );

   // Pointer update; a direct pointer write overrides traffic movement
   always_comb
   begin
      tx_head_d = tx_head_q;
      tx_tail_d = tx_tail_q;
      rx_head_d = rx_head_q;
      rx_tail_d = rx_tail_q;
      if (tx_pop || sw_tx_win_rd)
      begin
         tx_head_d = tx_head_q + PW'(1);
      end
      if (tx_push || sw_tx_win_wr)
      begin
         tx_tail_d = tx_tail_q + PW'(1);
      end
      if (rx_pop || sw_rx_win_rd)
      begin
         rx_head_d = rx_head_q + PW'(1);
      end
      if (rx_push || sw_rx_win_wr)
      begin
         rx_tail_d = rx_tail_q + PW'(1);
      end
      if (wr_cyc)
      begin
         unique case (addr_q)
            `DFAL_TX_HEAD_OFS: tx_head_d = HWDATA[PW-1:0];
            `DFAL_TX_TAIL_OFS: tx_tail_d = HWDATA[PW-1:0];
            `DFAL_RX_HEAD_OFS: rx_head_d = HWDATA[PW-1:0];
            `DFAL_RX_TAIL_OFS: rx_tail_d = HWDATA[PW-1:0];
            default:
            begin
            end
         endcase
      end
   end

   // Pointers clear to two empty FIFOs
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         tx_head_q <= '0;
         tx_tail_q <= '0;
         rx_head_q <= '0;
         rx_tail_q <= '0;
      end
      else
      begin
         tx_head_q <= tx_head_d;
         tx_tail_q <= tx_tail_d;
         rx_head_q <= rx_head_d;
         rx_tail_q <= rx_tail_d;
      end
   end

   // Control register write
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_cyc && (addr_q == `DFAL_CTRL_OFS))
      begin
         ctrl_d = HWDATA[5:0];
      end
   end

   // Control clears with the loop open
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         ctrl_q <= `DFAL_CTRL_RESET;
      end
      else
      begin
         ctrl_q <= ctrl_d;
      end
   end

   // Bus phase tracking and read data capture
   always_comb
   begin
      phase_d = phase_q;
      addr_d = addr_q;
      rdata_d = rdata_q;
      if (phase_q != dfal_pkg::PH_RD_WAIT)
      begin
         if (addr_take)
         begin
            addr_d = {HADDR[7:2], 2'b00};
            phase_d = HWRITE ? dfal_pkg::PH_WRITE : dfal_pkg::PH_RD_WAIT;
         end
         else
         begin
            phase_d = dfal_pkg::PH_IDLE;
         end
      end
      else
      begin
         phase_d = dfal_pkg::PH_RD_DONE;
         unique case (addr_q)
            `DFAL_TX_HEAD_OFS: rdata_d = 32'(tx_head_q);
            `DFAL_TX_TAIL_OFS: rdata_d = 32'(tx_tail_q);
            `DFAL_RX_HEAD_OFS: rdata_d = 32'(rx_head_q);
            `DFAL_RX_TAIL_OFS: rdata_d = 32'(rx_tail_q);
            `DFAL_TX_WIN_OFS: rdata_d = tx_rd_data;
            `DFAL_RX_WIN_OFS: rdata_d = rx_rd_data;
            `DFAL_CTRL_OFS: rdata_d = 32'(ctrl_q);
            `DFAL_STATUS_OFS: rdata_d = {27'h000_0000, rx_full, rx_empty,
               tx_full, tx_empty, lb_act};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      // No byte lanes exist, so software must use whole words on the window
      if (HSIZE != 3'h2)
      begin
         addr_d = addr_d; // Narrow sizes are treated as word accesses
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         phase_q <= dfal_pkg::PH_IDLE;
         addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         phase_q <= phase_d;
         addr_q <= addr_d;
         rdata_q <= rdata_d;
      end
   end

endmodule : dfal_top

`default_nettype wire

/* File: dfal_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none

module dfal_top_sva (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic [31:0] HRDATA,
   input wire logic LINE_TX_VALID,
   input wire logic LINE_TX_READY,
   input wire logic LINE_RX_VALID,
   input wire logic RX_OUT_VALID,
   input wire logic RX_OUT_READY,
   input wire logic LOOPBACK_ACTIVE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // NONSEQ and SEQ both have bit 1 set
   wire taken = HSEL && HREADY && HTRANS[1];

   // Bus timing and response
   a_bus_okay: assert property (HRESP == 1'b0)
      else $error("bus response not okay");
   a_read_wait: assert property (taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read data phase not one wait cycle");
   a_write_nowait: assert property (taken && HWRITE |=> HREADYOUT)
      else $error("write data phase stalled");
   a_rdata_hold: assert property (!$stable(HRDATA) |-> $past(HREADYOUT) == 1'b0)
      else $error("read data changed outside a read");
   // Line transmit idles in loopback; traffic flags move only by traffic unless software touched the bus
   a_lb_tx_idle: assert property (LOOPBACK_ACTIVE |-> !LINE_TX_VALID)
      else $error("line transmit active during loopback");
   a_tx_hold: assert property (
      LINE_TX_VALID && !LINE_TX_READY && !HSEL && !$past(HSEL) |=> LINE_TX_VALID)
      else $error("transmit word lost without pop");
   a_rx_hold: assert property (
      RX_OUT_VALID && !RX_OUT_READY && !HSEL && !$past(HSEL) |=> RX_OUT_VALID)
      else $error("receive word lost without pop");
   a_rx_quiet: assert property (
      !RX_OUT_VALID && !LINE_RX_VALID && !LOOPBACK_ACTIVE && !HSEL && !$past(HSEL)
      |=> !RX_OUT_VALID)
      else $error("receive word appeared from nowhere");
endmodule : dfal_top_sva

bind dfal_top dfal_top_sva dfal_top_sva_i (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .HRDATA(HRDATA), .LINE_TX_VALID(LINE_TX_VALID), .LINE_TX_READY(LINE_TX_READY),
   .LINE_RX_VALID(LINE_RX_VALID), .RX_OUT_VALID(RX_OUT_VALID),
   .RX_OUT_READY(RX_OUT_READY), .LOOPBACK_ACTIVE(LOOPBACK_ACTIVE));

`default_nettype wire

/* File: test_diag_fifo_access_loopback.sv */
`include "dfal_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module test_diag_fifo_access_loopback;
   logic CLK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0, TX_IN_VALID = 0;
   logic LINE_TX_READY = 0, LINE_RX_VALID = 0, RX_OUT_READY = 0;
   logic [1:0] HTRANS = 2'h0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, TX_IN_DATA = 32'h0, LINE_RX_DATA = 32'h0;
   logic HREADYOUT, HRESP, TX_IN_READY, LINE_TX_VALID, RX_OUT_VALID, LOOPBACK_ACTIVE;
   logic [31:0] HRDATA, LINE_TX_DATA, RX_OUT_DATA, rd;
   wire [2:0] flg = {HREADYOUT, LINE_TX_VALID, RX_OUT_VALID};
   int fails = 0, n_tests = 0, n, i;
   // Rows: offset, write value, read-back value (5-bit pointers, 6-bit control)
   logic [31:0] rows [6][3] = '{'{32'h00, 32'h0000_0003, 32'h03},
      '{32'h04, 32'h0000_0015, 32'h15}, '{32'h08, 32'hFFFF_FFE7, 32'h07},
      '{32'h0C, 32'h0000_0010, 32'h10}, '{32'h18, 32'hFFFF_FFFF, 32'h3F},
      '{32'h20, 32'h1234_5678, 32'h00}};
   // Control settings and whether each closes the loop
   logic [7:0] lb [6] = '{8'h0B, 8'h03, 8'h09, 8'h1B, 8'h0F, 8'h07};
   logic [5:0] lbe = 6'h31;

   always #4 CLK = ~CLK;

   dfal_top dfal_top_i (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
      .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .TX_IN_VALID(TX_IN_VALID),
      .TX_IN_DATA(TX_IN_DATA), .TX_IN_READY(TX_IN_READY), .LINE_TX_VALID(LINE_TX_VALID),
      .LINE_TX_DATA(LINE_TX_DATA), .LINE_TX_READY(LINE_TX_READY),
      .LINE_RX_VALID(LINE_RX_VALID), .LINE_RX_DATA(LINE_RX_DATA),
      .RX_OUT_VALID(RX_OUT_VALID), .RX_OUT_DATA(RX_OUT_DATA), .RX_OUT_READY(RX_OUT_READY),
      .LOOPBACK_ACTIVE(LOOPBACK_ACTIVE));

   task conclude();
      if (fails == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Bounded wait on a flag: 0 rx valid, 1 line tx valid, 2 bus ready
   task wt(input int k);
      for (n = 0; n < 20; n++)
      begin
         @(posedge CLK);
         if (flg[k] === 1'b1)
            return;
      end
      $display("CHECK FAILED at %0t: wait timed out", $time);
      fails++;
      conclude();
   endtask : wt

   // One AHB single word transfer; read data lands in rd
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= `DFAL_HTRANS_NONSEQ;
      HWRITE <= wr;
      HADDR <= {24'h0, a};
      wt(2);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      wt(2);
      rd = HRDATA;
   endtask : bus

   initial
   begin
      repeat (3) @(posedge CLK);
      RESET_N <= 1'b1;
      for (i = 0; i < 6; i++)
      begin
         bus(1'b1, rows[i][0][7:0], rows[i][1]);
         bus(1'b0, rows[i][0][7:0], 32'h0);
         chk(rd, rows[i][2]);
      end
      // Mid-run reset, then every register except the two windows back to reset values
      RESET_N <= 1'b0;
      repeat (3) @(posedge CLK);
      RESET_N <= 1'b1;
      for (i = 0; i < 8; i++)
      begin
         if (i == 4 || i == 5)
            continue;
         bus(1'b0, 8'(i * 4), 32'h0);
         chk(rd, (i == 7) ? 32'h0000_000A : 32'h0);
      end
      chk({TX_IN_READY, LINE_TX_VALID, RX_OUT_VALID}, 32'h4);
      // Window write and read through freshly written pointers, back to back
      for (i = 0; i < 2; i++)
      begin
         bus(1'b1, 8'(i * 8 + 4), 32'h9);
         bus(1'b1, 8'(16 + i * 4), 32'hA5C3_0F10 + i);
         bus(1'b1, 8'(i * 8), 32'h9);
         bus(1'b0, 8'(16 + i * 4), 32'h0);
         chk(rd, 32'hA5C3_0F10 + i);
         bus(1'b0, 8'(i * 8), 32'h0);
         chk(rd, 32'hA);
         bus(1'b0, 8'(i * 8 + 4), 32'h0);
         chk(rd, 32'hA);
      end
      // Loop closes only at full duplex, at any speed setting but 10 Mb/s, with normal select
      for (i = 0; i < 6; i++)
      begin
         // The enable bit stands in for the management writes that close the loop
         bus(1'b1, `DFAL_CTRL_OFS, {24'h0, lb[i]});
         bus(1'b0, `DFAL_STATUS_OFS, 32'h0);
         chk(rd[0], lbe[i]);
         chk(LOOPBACK_ACTIVE, lbe[i]);
      end
      // Looped word returns; a line word in the same cycle is dropped
      TX_IN_DATA <= 32'h1357_9BDF;
      TX_IN_VALID <= 1'b1;
      LINE_RX_DATA <= 32'hDEAD_0001;
      LINE_RX_VALID <= 1'b1;
      @(posedge CLK);
      TX_IN_VALID <= 1'b0;
      LINE_RX_VALID <= 1'b0;
      wt(0);
      chk(RX_OUT_DATA, 32'h1357_9BDF);
      chk(LINE_TX_VALID, 1'b0);
      RX_OUT_READY <= 1'b1;
      @(posedge CLK);
      RX_OUT_READY <= 1'b0;
      @(posedge CLK);
      chk(RX_OUT_VALID, 1'b0);
      // At 10 Mb/s the word goes to the line instead
      bus(1'b1, `DFAL_CTRL_OFS, 32'h3);
      TX_IN_DATA <= 32'h2468_ACE0;
      TX_IN_VALID <= 1'b1;
      @(posedge CLK);
      TX_IN_VALID <= 1'b0;
      wt(1);
      repeat (2) @(posedge CLK);
      chk(LINE_TX_DATA, 32'h2468_ACE0);
      LINE_TX_READY <= 1'b1;
      LINE_RX_DATA <= 32'h0F0F_1234;
      LINE_RX_VALID <= 1'b1;
      @(posedge CLK);
      LINE_TX_READY <= 1'b0;
      LINE_RX_VALID <= 1'b0;
      wt(0);
      chk(RX_OUT_DATA, 32'h0F0F_1234);
      chk(LINE_TX_VALID, 1'b0);
      // Tail one lap ahead of head: full, so the host push is refused
      bus(1'b1, `DFAL_TX_TAIL_OFS, 32'h0000_001C);
      bus(1'b0, `DFAL_STATUS_OFS, 32'h0);
      chk(rd, 32'h0000_0004);
      chk(TX_IN_READY, 1'b0);
      conclude();
   end
endmodule : test_diag_fifo_access_loopback

`default_nettype wire
